//--- logic/port_b_fn_pkg.sv
package port_b_fn_pkg;

   // Register bus geometry.
   localparam int ADDR_W = 3;
   localparam int DATA_W = 16;
   localparam int PIN_COUNT = 20;

   // Register indices on the plain register port.
   localparam logic [2:0] REG_HIGH1 = 3'h0;
   localparam logic [2:0] REG_LOW4 = 3'h1;
   localparam logic [2:0] REG_LOW3 = 3'h2;
   localparam logic [2:0] REG_LOW2 = 3'h3;
   localparam logic [2:0] REG_LOW1 = 3'h4;
   localparam int REG_COUNT = 5;

   // Writable bits per register; all other bits are reserved.
   localparam logic [15:0] WR_MASK [0:4] = '{
      16'h7777, 16'h7777, 16'h7777, 16'h7700, 16'h7777};

   // Fields whose lowest bit is set at reset in the ROM-less boot mode.
   localparam logic [15:0] BOOT_MASK [0:4] = '{
      16'h1111, 16'h1001, 16'h1001, 16'h1100, 16'h0011};

   // Register index and field position for each pin.
   localparam logic [2:0] PIN_REG [0:19] = '{
      REG_LOW1, REG_LOW1, REG_LOW1, REG_LOW1,
      REG_LOW2, REG_LOW2, REG_LOW2, REG_LOW2,
      REG_LOW3, REG_LOW3, REG_LOW3, REG_LOW3,
      REG_LOW4, REG_LOW4, REG_LOW4, REG_LOW4,
      REG_HIGH1, REG_HIGH1, REG_HIGH1, REG_HIGH1};
   localparam int PIN_LSB [0:19] = '{
      0, 4, 8, 12, 0, 0, 8, 12, 0, 4, 8, 12,
      0, 4, 8, 12, 0, 4, 8, 12};

   // Pins that may only be inputs while in port mode.
   localparam logic [19:0] PORT_IN_ONLY = 20'h0000c;

   // Function codes of a three-bit pin field.
   typedef enum logic [2:0] {
      FN_PORT = 3'h0,
      FN_1    = 3'h1,
      FN_2    = 3'h2,
      FN_3    = 3'h3,
      FN_4    = 3'h4,
      FN_5    = 3'h5,
      FN_6    = 3'h6,
      FN_7    = 3'h7
   } fn_e;

   // Signals that on-chip peripherals offer to the pins.
   typedef struct packed {
      logic [9:0] addr_hi;
      logic       refresh_request_out;
      logic       row_strobe_upper;
      logic       row_strobe_lower;
      logic       col_strobe_upper;
      logic       col_strobe_lower;
      logic       sdram_cke;
      logic [7:0] chip_select;
      logic       serial_tx0;
      logic       serial_tx2;
      logic       can_tx0;
      logic       usb_suspend_out;
      logic       serial_clock0_out;
      logic       serial_clock0_drv;
      logic       i2c_sda_out;
      logic       i2c_sda_drv;
      logic       i2c_scl_out;
      logic       i2c_scl_drv;
   } periph_out_s;

   // Pin levels routed to on-chip peripherals.
   typedef struct packed {
      logic [7:0] ext_interrupt;
      logic       output_disable_in1;
      logic       output_disable_in2;
      logic       output_disable_in3;
      logic       output_disable_in4;
      logic       output_disable_in8;
      logic       bus_wait;
      logic       bus_request;
      logic       bus_grant;
      logic       serial_rx0;
      logic       serial_rx2;
      logic       serial_clock0_in;
      logic       i2c_sda_in;
      logic       i2c_scl_in;
      logic       adc_ext_trigger;
      logic       can_rx0;
      logic       dma_request2;
      logic       dma_request3;
      logic       dma_ack2;
      logic       dma_ack3;
   } periph_in_s;

endpackage

//--- logic/port_b_pin_function_select.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Pin 9 field, bits 6:4, reset 000: port or USB suspend output.
// - Pin 8 field, bits 2:0: port, A20, wait, ext_interrupt7, disable8, clock0.
// - Pin 7 field, bits 14:12: port, A19, bus request, ext_interrupt6, tx0.
// - Pin 6 field, bits 10:8: port, A18, bus grant, ext_interrupt5, rx0.
// - Pin 3 field, bits 14:12, reset 000: input, ext_interrupt1, disable2, SDA.
// - Pin 2 field, bits 10:8, reset 000: input, ext_interrupt0, disable1, SCL.
// - Pin 1 field, bits 6:4: port, A17, refresh out, ext_interrupt4, ADC trigger.
// - Pin 0 field, bits 2:0: port, A16, ext_interrupt3.
// - Pin 19 field, bits 14:12: port, A25, upper row strobe, DMA req2.
// - Pin 18 field, bits 10:8: port, A24, lower row strobe, DMA ack2.
// - Pin 17 field, bits 6:4: port, A23, upper column strobe, req3.
// - Pin 16 field, bits 2:0: port, A22, lower column strobe, ack3.
// - Pin 15 field, bits 14:12: port, A21, SDRAM clock enable.
// - Pin 14 field, bits 10:8, reset 000: port or CAN receive.
// - Pin 13 field, bits 6:4, reset 000: port or CAN transmit.
// - Pin 12 field, bits 2:0: port, selects 1/7/3, ext_interrupt1, tx2.
// - Pin 11 field, bits 14:12: port, selects 0/6/2, ext_interrupt0, rx2.
// - Reserved bits read as zero; software writes zero there.
// - Boot-dependent fields reset with bit 0 set in ROM-less boot.

module port_b_pin_function_select #(
   parameter int PINS = port_b_fn_pkg::PIN_COUNT
) (
   // Clock and reset.
   input  wire logic                        clk,
   input  wire logic                        rst_b,
   // Boot strap: high in the ROM-less external extension mode.
   input  wire logic                        ext_rom_off_mode,
   // Register port.
   input  wire logic [port_b_fn_pkg::ADDR_W-1:0] addr,
   input  wire logic [port_b_fn_pkg::DATA_W-1:0] wr_data,
   input  wire logic                        wr_en,
   input  wire logic                        rd_en,
   output      logic [port_b_fn_pkg::DATA_W-1:0] rd_data_q,
   // Port data and direction from the port registers.
   input  wire logic [PINS-1:0]             port_out,
   input  wire logic [PINS-1:0]             port_dir,
   // Peripheral side.
   input  wire port_b_fn_pkg::periph_out_s  periph_out,
   output      port_b_fn_pkg::periph_in_s   periph_in_q,
   // Pad side.
   input  wire logic [PINS-1:0]             pin_in,
   output      logic [PINS-1:0]             pin_out_q,
   output      logic [PINS-1:0]             pin_oe_b_q
);
   import port_b_fn_pkg::*;

   logic [DATA_W-1:0] regs_q [0:REG_COUNT-1];
   fn_e               fn     [0:PINS-1];
   logic [7:0]        sel    [0:PINS-1];
   logic [PINS-1:0]   alt_val;
   logic [PINS-1:0]   alt_drv;
   periph_in_s        periph_in_d;

   // Control registers. Only writable bits are stored, so reserved bits
   // can never hold a one and need no masking on read.
   always_ff @(posedge clk) begin
      for (int i = 0; i < REG_COUNT; i++) begin
         if (!rst_b) begin
            regs_q[i] <= ext_rom_off_mode ? BOOT_MASK[i] : 16'h0000;
         end else if (wr_en && addr == 3'(i)) begin
            regs_q[i] <= wr_data & WR_MASK[i];
         end
      end
   end

   // Read data stands only in the cycle after the read strobe; an
   // unmapped index answers zero.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rd_data_q <= 16'h0000;
      end else if (rd_en && addr < 3'(REG_COUNT)) begin
         rd_data_q <= regs_q[addr];
      end else begin
         rd_data_q <= 16'h0000;
      end
   end

   // Field extraction and one-hot code decode per pin. Pins 4 and 5 map
   // onto reserved bits, so they always decode as port pins.
   for (genvar p = 0; p < PINS; p++) begin : g_field
      assign fn[p]  = fn_e'(regs_q[PIN_REG[p]][PIN_LSB[p] +: 3]);
      assign sel[p] = 8'h01 << fn[p];
   end

   // Alternate output value and drive per pin. A prohibited code leaves
   // the pin undriven, which is the least harmful reading of bad software.
   always_comb begin
      alt_val = '0;
      alt_drv = '0;

      // Pin 0.
      alt_val[0] = periph_out.addr_hi[0];
      alt_drv[0] = sel[0][FN_1];

      // Pin 1.
      alt_val[1] = sel[1][FN_2] ? periph_out.refresh_request_out
                                : periph_out.addr_hi[1];
      alt_drv[1] = sel[1][FN_1] | sel[1][FN_2];

      // Pin 2, open drain clock of the two-wire bus.
      alt_val[2] = periph_out.i2c_scl_out;
      alt_drv[2] = sel[2][FN_5] & periph_out.i2c_scl_drv;

      // Pin 3, open drain data of the two-wire bus.
      alt_val[3] = periph_out.i2c_sda_out;
      alt_drv[3] = sel[3][FN_5] & periph_out.i2c_sda_drv;

      // Pin 6.
      alt_val[6] = periph_out.addr_hi[2];
      alt_drv[6] = sel[6][FN_1];

      // Pin 7.
      alt_val[7] = sel[7][FN_5] ? periph_out.serial_tx0
                                : periph_out.addr_hi[3];
      alt_drv[7] = sel[7][FN_1] | sel[7][FN_5];

      // Pin 8; the serial clock drives only when the serial block asks.
      alt_val[8] = sel[8][FN_5] ? periph_out.serial_clock0_out
                                : periph_out.addr_hi[4];
      alt_drv[8] = sel[8][FN_1] |
                   (sel[8][FN_5] & periph_out.serial_clock0_drv);

      // Pin 9.
      alt_val[9] = periph_out.usb_suspend_out;
      alt_drv[9] = sel[9][FN_5];

      // Pin 11.
      alt_val[11] = (sel[11][FN_1] & periph_out.chip_select[0]) |
                    (sel[11][FN_2] & periph_out.chip_select[6]) |
                    (sel[11][FN_7] & periph_out.chip_select[2]);
      alt_drv[11] = sel[11][FN_1] | sel[11][FN_2] | sel[11][FN_7];

      // Pin 12.
      alt_val[12] = (sel[12][FN_1] & periph_out.chip_select[1]) |
                    (sel[12][FN_2] & periph_out.chip_select[7]) |
                    (sel[12][FN_5] & periph_out.serial_tx2) |
                    (sel[12][FN_7] & periph_out.chip_select[3]);
      alt_drv[12] = sel[12][FN_1] | sel[12][FN_2] |
                    sel[12][FN_5] | sel[12][FN_7];

      // Pin 13.
      alt_val[13] = periph_out.can_tx0;
      alt_drv[13] = sel[13][FN_5];

      // Pin 15.
      alt_val[15] = sel[15][FN_2] ? periph_out.sdram_cke
                                  : periph_out.addr_hi[5];
      alt_drv[15] = sel[15][FN_1] | sel[15][FN_2];

      // Pin 16.
      alt_val[16] = sel[16][FN_2] ? periph_out.col_strobe_lower
                                  : periph_out.addr_hi[6];
      alt_drv[16] = sel[16][FN_1] | sel[16][FN_2];

      // Pin 17.
      alt_val[17] = sel[17][FN_2] ? periph_out.col_strobe_upper
                                  : periph_out.addr_hi[7];
      alt_drv[17] = sel[17][FN_1] | sel[17][FN_2];

      // Pin 18.
      alt_val[18] = sel[18][FN_2] ? periph_out.row_strobe_lower
                                  : periph_out.addr_hi[8];
      alt_drv[18] = sel[18][FN_1] | sel[18][FN_2];

      // Pin 19.
      alt_val[19] = sel[19][FN_2] ? periph_out.row_strobe_upper
                                  : periph_out.addr_hi[9];
      alt_drv[19] = sel[19][FN_1] | sel[19][FN_2];
   end

   // Pin levels to peripherals. An input that is not routed holds zero,
   // so a peripheral never sees a pin that belongs to another function.
   always_comb begin
      periph_in_d = '0;

      // External interrupts; two lines each have two candidate pins.
      periph_in_d.ext_interrupt[0] = (sel[2][FN_3] & pin_in[2]) |
                                     (sel[11][FN_3] & pin_in[11]);
      periph_in_d.ext_interrupt[1] = (sel[3][FN_3] & pin_in[3]) |
                                     (sel[12][FN_3] & pin_in[12]);
      periph_in_d.ext_interrupt[3] = sel[0][FN_3] & pin_in[0];
      periph_in_d.ext_interrupt[4] = sel[1][FN_3] & pin_in[1];
      periph_in_d.ext_interrupt[5] = sel[6][FN_3] & pin_in[6];
      periph_in_d.ext_interrupt[6] = sel[7][FN_3] & pin_in[7];
      periph_in_d.ext_interrupt[7] = sel[8][FN_3] & pin_in[8];

      // Output disable requests.
      periph_in_d.output_disable_in1 = sel[2][FN_4] & pin_in[2];
      periph_in_d.output_disable_in2 = sel[3][FN_4] & pin_in[3];
      periph_in_d.output_disable_in3 = sel[6][FN_4] & pin_in[6];
      periph_in_d.output_disable_in4 = sel[7][FN_4] & pin_in[7];
      periph_in_d.output_disable_in8 = sel[8][FN_4] & pin_in[8];

      // Bus controller inputs.
      periph_in_d.bus_wait    = sel[8][FN_2] & pin_in[8];
      periph_in_d.bus_request = sel[7][FN_2] & pin_in[7];
      periph_in_d.bus_grant   = sel[6][FN_2] & pin_in[6];

      // Serial, two-wire, converter trigger and CAN inputs.
      periph_in_d.serial_rx0       = sel[6][FN_5] & pin_in[6];
      periph_in_d.serial_rx2       = sel[11][FN_5] & pin_in[11];
      periph_in_d.serial_clock0_in = sel[8][FN_5] & pin_in[8];
      periph_in_d.i2c_sda_in       = sel[3][FN_5] & pin_in[3];
      periph_in_d.i2c_scl_in       = sel[2][FN_5] & pin_in[2];
      periph_in_d.adc_ext_trigger  = sel[1][FN_7] & pin_in[1];
      periph_in_d.can_rx0          = sel[14][FN_5] & pin_in[14];

      // DMA request and acknowledge lines.
      periph_in_d.dma_request2 = sel[19][FN_7] & pin_in[19];
      periph_in_d.dma_ack2     = sel[18][FN_7] & pin_in[18];
      periph_in_d.dma_request3 = sel[17][FN_7] & pin_in[17];
      periph_in_d.dma_ack3     = sel[16][FN_7] & pin_in[16];
   end

   // Peripheral inputs are registered, costing one cycle of latency in
   // exchange for glitch-free levels when a field changes.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         periph_in_q <= '0;
      end else begin
         periph_in_q <= periph_in_d;
      end
   end

   // Pad drivers. In port mode the port direction decides, except on the
   // input-only pins; otherwise the selected function decides.
   for (genvar p = 0; p < PINS; p++) begin : g_pad
      always_ff @(posedge clk) begin
         if (!rst_b) begin
            pin_out_q[p]  <= 1'b0;
            pin_oe_b_q[p] <= 1'b1;
         end else if (sel[p][FN_PORT]) begin
            pin_out_q[p]  <= port_out[p];
            pin_oe_b_q[p] <= ~port_dir[p] | PORT_IN_ONLY[p];
         end else begin
            pin_out_q[p]  <= alt_val[p];
            pin_oe_b_q[p] <= ~alt_drv[p];
         end
      end
   end

endmodule // port_b_pin_function_select

//--- verif/periph_model.sv
`timescale 1ns/10ps
module periph_model (
   // Clock and freeze control.
   input  wire logic                  clk,
   input  wire logic                  hold,
   // Levels offered to the pin selector.
   output port_b_fn_pkg::periph_out_s periph_out,
   output logic [19:0]                pin_in
);
   import port_b_fn_pkg::*;

   // Peripherals and pads move every cycle; freezing lets the bench predict.
   initial begin
      periph_out = '0;
      pin_in = 20'h0;
   end
   always @(posedge clk) begin
      if (!hold) begin
         // Two random words are cut to the struct's width before the cast.
         periph_out <= periph_out_s'(
            $bits(periph_out_s)'({$urandom(), $urandom()}));
         pin_in <= 20'($urandom());
      end
   end
endmodule // periph_model

//--- verif/port_b_fn_checker.sv
`timescale 1ns/10ps
module port_b_fn_checker #(
   parameter int PINS = 20
) (
   // Clock, reset and boot strap.
   input wire logic                       clk,
   input wire logic                       rst_b,
   input wire logic                       ext_rom_off_mode,
   // Register port.
   input wire logic [2:0]                 addr,
   input wire logic [15:0]                wr_data,
   input wire logic                       wr_en,
   input wire logic                       rd_en,
   input wire logic [15:0]                rd_data_q,
   // Port, peripheral and pad side.
   input wire logic [PINS-1:0]            port_out,
   input wire logic [PINS-1:0]            port_dir,
   input wire port_b_fn_pkg::periph_out_s periph_out,
   input wire port_b_fn_pkg::periph_in_s  periph_in_q,
   input wire logic [PINS-1:0]            pin_in,
   input wire logic [PINS-1:0]            pin_out_q,
   input wire logic [PINS-1:0]            pin_oe_b_q
);
   import port_b_fn_pkg::*;
   logic [15:0] shadow_q [0:4];
   logic [2:0]  f0, f8, f9, f14, f15, f2, f3;

   // Mirror of the registers, so pad checks know every field code.
   always_ff @(posedge clk) begin
      for (int i = 0; i < 5; i++) begin
         if (!rst_b) shadow_q[i] <= ext_rom_off_mode ? BOOT_MASK[i] : 16'h0;
         else if (wr_en && addr == 3'(i)) shadow_q[i] <= wr_data & WR_MASK[i];
      end
   end
   assign f0 = shadow_q[4][2:0];
   assign f2 = shadow_q[4][10:8];
   assign f3 = shadow_q[4][14:12];
   assign f8 = shadow_q[2][2:0];
   assign f9 = shadow_q[2][6:4];
   assign f14 = shadow_q[1][10:8];
   assign f15 = shadow_q[1][14:12];

   // Pad flops lag the fields by one edge, so antecedents use past values.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   chk_read_idle: assert property (!$past(rd_en) |-> rd_data_q == 16'h0)
      else $error("read data not zero outside read cycle");
   chk_read_mirror: assert property (rd_en && addr < 3'h5 |=>
      rd_data_q == shadow_q[$past(addr)]) else $error("read data mismatch");
   chk_reserved_zero: assert property ((rd_data_q & 16'h8888) == 16'h0)
      else $error("reserved bit read as one");
   chk_unmapped_read: assert property (rd_en && addr > 3'h4 |=>
      rd_data_q == 16'h0) else $error("unmapped read not zero");
   chk_reset_pads: assert property ($rose(rst_b) |->
      &pin_oe_b_q && pin_out_q == '0) else $error("pads not idle after reset");
   chk_port_mode: assert property ($past(rst_b) && $past(f0) == 3'h0 |->
      pin_oe_b_q[0] == !$past(port_dir[0])) else $error("pin 0 port enable");
   chk_addr_route: assert property ($past(rst_b) && $past(f8) == 3'h1 |->
      !pin_oe_b_q[8] && pin_out_q[8] == $past(periph_out.addr_hi[4]))
      else $error("pin 8 address route");
   chk_prohibited: assert property ($past(rst_b) && $past(f15) > 3'h2 |->
      pin_oe_b_q[15]) else $error("pin 15 driven on prohibited code");
   chk_input_only: assert property ($past(rst_b) && $past(f2) == 3'h0 &&
      $past(f3) == 3'h0 |-> pin_oe_b_q[3:2] == 2'h3)
      else $error("input-only pin driven");
   chk_usb_route: assert property ($past(rst_b) && $past(f9) == 3'h5 |->
      !pin_oe_b_q[9] && pin_out_q[9] == $past(periph_out.usb_suspend_out))
      else $error("pin 9 suspend route");
   chk_can_route: assert property ($past(rst_b) |->
      periph_in_q.can_rx0 == ($past(f14) == 3'h5 && $past(pin_in[14])))
      else $error("receive route of pin 14");
endmodule // port_b_fn_checker

//--- verif/tb.sv
`timescale 1ns/10ps
module tb;
   import port_b_fn_pkg::*;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        boot = 1'b0;
   logic [2:0]  addr = 3'h0;
   logic [15:0] wr_data = 16'h0;
   logic        wr_en = 1'b0;
   logic        rd_en = 1'b0;
   logic        hold = 1'b0;
   logic        rd_seen = 1'b0;
   logic [19:0] port_out = 20'h0;
   logic [19:0] port_dir = 20'h0;
   logic [15:0] rd_data_q;
   logic [19:0] pin_in, pin_out_q, pin_oe_b_q;
   periph_out_s periph_out;
   periph_in_s  periph_in_q;
   logic [15:0] exp_q[$];
   int          n_fail = 0;
   int          n_compared = 0;

   always #10 clk = ~clk;

   // Device with its peripheral side modelled.
   port_b_pin_function_select dut_u (.clk(clk), .rst_b(rst_b),
      .ext_rom_off_mode(boot), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q),
      .port_out(port_out), .port_dir(port_dir), .periph_out(periph_out),
      .periph_in_q(periph_in_q), .pin_in(pin_in), .pin_out_q(pin_out_q),
      .pin_oe_b_q(pin_oe_b_q));
   periph_model model_u (.clk(clk), .hold(hold), .periph_out(periph_out),
      .pin_in(pin_in));

   task automatic cmp(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   // wr and rd each raise their strobe at an edge; idle or a call of the other kind drops it.
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      rd_en <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      wr_en <= 1'b0;
      exp_q.push_back(e);
   endtask
   task automatic idle();
      @(posedge clk);
      wr_en <= 1'b0;
      rd_en <= 1'b0;
   endtask

   // Read data are valid only in the cycle after the strobe.
   always @(posedge clk) rd_seen <= rd_en && rst_b;
   always @(negedge clk) begin
      if (rd_seen) cmp("rd_data_q", exp_q.pop_front(), rd_data_q);
   end

   // Reset in a given boot mode, then read every index back.
   task automatic reset_and_read(input logic b);
      @(posedge clk);
      rst_b <= 1'b0;
      boot <= b;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 8; i++) rd(3'(i), (b && i < 5) ? BOOT_MASK[i] : 16'h0);
      idle();
   endtask

   // Frozen inputs make the routed pad and peripheral levels predictable.
   task automatic pad(input logic [2:0] a, input logic [15:0] d);
      hold <= 1'b0;
      wr(a, d);
      hold <= 1'b1;
      port_out <= 20'($urandom());
      port_dir <= 20'($urandom());
      idle();
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic conclude();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // A hang is cut off well beyond the roughly 150 cycles expected.
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      conclude();
   end

   initial begin
      logic [2:0]  a;
      logic [15:0] d;
      void'($urandom(7));
      reset_and_read(1'b0);
      for (int i = 0; i < 8; i++) begin
         wr(3'(i), 16'hffff);
         rd(3'(i), i < 5 ? WR_MASK[i] : 16'h0);
      end
      repeat (20) begin
         a = 3'($urandom_range(4));
         d = 16'($urandom());
         wr(a, d);
         rd(a, d & WR_MASK[a]);
      end
      pad(REG_LOW3, 16'h0001);
      cmp("pin8", {1'b0, periph_out.addr_hi[4]}, {pin_oe_b_q[8], pin_out_q[8]});
      pad(REG_LOW3, 16'h0006);
      cmp("pin8_off", 16'h1, pin_oe_b_q[8]);
      cmp("pin11", !port_dir[11], pin_oe_b_q[11]);
      // Pin 2 must not share the interrupt line in the next check.
      wr(REG_LOW1, 16'h0000);
      pad(REG_LOW3, 16'h3050);
      cmp("pin9", {1'b0, periph_out.usb_suspend_out}, {pin_oe_b_q[9], pin_out_q[9]});
      cmp("ext_interrupt0", pin_in[11], periph_in_q.ext_interrupt[0]);
      pad(REG_LOW4, 16'h2507);
      cmp("pin12", {1'b0, periph_out.chip_select[3]}, {pin_oe_b_q[12], pin_out_q[12]});
      cmp("can_rx0", pin_in[14], periph_in_q.can_rx0);
      cmp("pin15", {1'b0, periph_out.sdram_cke}, {pin_oe_b_q[15], pin_out_q[15]});
      pad(REG_HIGH1, 16'h7211);
      cmp("dma_request2", {1'b1, pin_in[19]}, {pin_oe_b_q[19], periph_in_q.dma_request2});
      cmp("pin18", {1'b0, periph_out.row_strobe_lower}, {pin_oe_b_q[18], pin_out_q[18]});
      cmp("pin17", {1'b0, periph_out.addr_hi[7]}, {pin_oe_b_q[17], pin_out_q[17]});
      cmp("pin16", {1'b0, periph_out.addr_hi[6]}, {pin_oe_b_q[16], pin_out_q[16]});
      pad(REG_LOW1, 16'h5370);
      cmp("pin0", !port_dir[0], pin_oe_b_q[0]);
      cmp("adc", pin_in[1], periph_in_q.adc_ext_trigger);
      cmp("ext_interrupt0_or", pin_in[2] | pin_in[11], periph_in_q.ext_interrupt[0]);
      cmp("pin3", !periph_out.i2c_sda_drv, pin_oe_b_q[3]);
      pad(REG_LOW2, 16'h1500);
      cmp("pin7", {1'b0, periph_out.addr_hi[3]}, {pin_oe_b_q[7], pin_out_q[7]});
      cmp("rx0", pin_in[6], periph_in_q.serial_rx0);
      reset_and_read(1'b1);
      pad(3'h7, 16'hffff);
      cmp("boot_pins", {2'h0, periph_out.addr_hi[1:0]}, {pin_oe_b_q[1:0], pin_out_q[1:0]});
      conclude();
   end
endmodule // tb

bind port_b_pin_function_select port_b_fn_checker #(.PINS(PINS)) chk_u (
   .clk(clk), .rst_b(rst_b), .ext_rom_off_mode(ext_rom_off_mode),
   .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
   .rd_data_q(rd_data_q), .port_out(port_out), .port_dir(port_dir),
   .periph_out(periph_out), .periph_in_q(periph_in_q), .pin_in(pin_in),
   .pin_out_q(pin_out_q), .pin_oe_b_q(pin_oe_b_q));
